//--- hdl/dtu_regs.vh
// Register map, control fields and timing constants of the dual module timer unit
`ifndef DTU_REGS_VH
`define DTU_REGS_VH

// Register word indexes; byte address is index times four
`define DTU_IDX_CTRL0 4'h0
`define DTU_IDX_CTRL4 4'h4
`define DTU_IDX_VAL0 4'h8
`define DTU_IDX_VAL4 4'hc
`define DTU_IDX_CAPTURE_RELOAD_REG 4'hd
`define DTU_IDX_FLAGS 4'he
`define DTU_ADDR_HI 2'h0

// Timer slots in every per-timer vector
`define DTU_T_AUXA 0
`define DTU_T_CORE 1
`define DTU_T_AUXB 2
`define DTU_T_SAUX 3
`define DTU_T_SCORE 4

// Control register fields
`define DTU_F_PS_HI 2
`define DTU_F_PS_LO 0
`define DTU_F_MODE_HI 4
`define DTU_F_MODE_LO 3
`define DTU_F_ROLE_HI 6
`define DTU_F_ROLE_LO 5
`define DTU_F_RUN 7
`define DTU_F_DOWN 8
`define DTU_F_EXTDIR 9
`define DTU_F_GATE_LVL 10
`define DTU_F_EDGE_RISE 11
`define DTU_F_EDGE_FALL 12
`define DTU_F_TGL_CLK 13
`define DTU_F_B14 14
`define DTU_F_B15 15
`define DTU_CTRL_RST 16'h0000

// Modes and roles
`define DTU_MODE_TIMER 2'h0
`define DTU_MODE_GATED 2'h1
`define DTU_MODE_COUNTER 2'h2
`define DTU_MODE_ENCODER 2'h3
`define DTU_ROLE_NONE 2'h0
`define DTU_ROLE_CAPTURE 2'h1
`define DTU_ROLE_RELOAD 2'h2

// Flag bits
`define DTU_FLG_CAPA 5
`define DTU_FLG_CAPB 6
`define DTU_FLG_CAPTURE_RELOAD_REG 7

// Finest resolution as log2 of system clocks per count
`define DTU_RES1_LOG2 4'h2
`define DTU_RES2_LOG2 4'h1

`define DTU_RESP_OKAY 2'h0
`define DTU_RESP_SLVERR 2'h2

`endif

//--- hdl/dtu_sync.v
// Two-stage pin synchroniser with edge detection behind the second stage
`timescale 1ns/100ps
module dtu_sync #(
    parameter W = 11
) (
    clk,
    rst_n,
    pin,
    level,
    rise,
    fall
);
    input wire clk;
    input wire rst_n;
    input wire [W-1:0] pin;
    output wire [W-1:0] level;
    output wire [W-1:0] rise;
    output wire [W-1:0] fall;

    reg [W-1:0] s1_reg;
    reg [W-1:0] s2_reg;
    reg [W-1:0] s3_reg;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= {W{1'b0}};
            s2_reg <= {W{1'b0}};
            s3_reg <= {W{1'b0}};
        end else begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    assign level = s2_reg;
    assign rise = s2_reg & ~s3_reg;
    assign fall = ~s2_reg & s3_reg;
endmodule

//--- hdl/dtu_timer.v
// One up/down timer with load and wrap detection
`timescale 1ns/100ps
module dtu_timer #(
    parameter W = 16
) (
    clk,
    rst_n,
    step,
    up,
    load,
    load_val,
    value,
    wrap
);
    input wire clk;
    input wire rst_n;
    input wire step;
    input wire up;
    input wire load;
    input wire [W-1:0] load_val;
    output wire [W-1:0] value;
    output wire wrap;

    reg [W-1:0] cnt_reg;

    // A load beats a count step, yet a due wrap is still reported: a reload
    // that is triggered by the wrap itself would otherwise form a loop
    assign wrap = step & (up ? (&cnt_reg) : ~(|cnt_reg));
    assign value = cnt_reg;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= {W{1'b0}};
        end else if (load) begin
            cnt_reg <= load_val;
        end else if (step) begin
            cnt_reg <= up ? cnt_reg + 1'b1 : cnt_reg - 1'b1;
        end
    end
endmodule

//--- hdl/dtu_top.v
// Dual module timer unit with AXI4-Lite register access
// How it works
// - five 16-bit timers in two modules
// - first module timers: timer, gated, counter, encoder
// - timer mode counts prescaled system clock
// - counter mode counts gate/clock pin edges
// - gated mode counts only while gate enables
// - first module timer/gated modes count at most every 4 clocks
// - first module direction by software or pin
// - encoder mode follows quadrature pins
// - core toggle latch flips on wrap, drives pin
// - core toggle latch can clock aux timers
// - capture or reload role stops aux timer
// - capture role latches core on pin edge
// - core reloads from aux on pin or toggle
// - opposite toggle reloads give free PWM
// - second module counts at most every 2 clocks unless counting both pin edges
// - second module prescaled or external clock
// - second module direction by software or pin
// - second toggle latch clocks aux, drives pin
// - second core wrap clocks out, reloads
// - capture pin latches second aux, optional clear
// - core gate/dir edges may trigger capture
`timescale 1ns/100ps
`include "dtu_regs.vh"
module dtu_top (
    CLOCK,
    RST_N,
    GATE_IN,
    DIR_IN,
    CAPTURE_IN,
    CORE_TOGGLE_OUT,
    SECOND_TOGGLE_OUT,
    SECOND_WRAP_PULSE,
    AWVALID,
    AWREADY,
    AWADDR,
    WVALID,
    WREADY,
    WDATA,
    WSTRB,
    BVALID,
    BREADY,
    BRESP,
    ARVALID,
    ARREADY,
    ARADDR,
    RVALID,
    RREADY,
    RDATA,
    RRESP
);
    input wire CLOCK;
    input wire RST_N;
    input wire [4:0] GATE_IN;
    input wire [4:0] DIR_IN;
    input wire CAPTURE_IN;
    output reg CORE_TOGGLE_OUT;
    output reg SECOND_TOGGLE_OUT;
    output reg SECOND_WRAP_PULSE;
    input wire AWVALID;
    output reg AWREADY;
    input wire [7:0] AWADDR;
    input wire WVALID;
    output reg WREADY;
    input wire [31:0] WDATA;
    input wire [3:0] WSTRB;
    output reg BVALID;
    input wire BREADY;
    output reg [1:0] BRESP;
    input wire ARVALID;
    output reg ARREADY;
    input wire [7:0] ARADDR;
    output reg RVALID;
    input wire RREADY;
    output reg [31:0] RDATA;
    output reg [1:0] RRESP;

    integer i;

    // Pin synchronisers
    wire [10:0] pin_lvl;
    wire [10:0] pin_rise;
    wire [10:0] pin_fall;

    dtu_sync #(.W(11)) u_sync (
        .clk(CLOCK),
        .rst_n(RST_N),
        .pin({CAPTURE_IN, DIR_IN, GATE_IN}),
        .level(pin_lvl),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    wire [4:0] gate_lvl = pin_lvl[4:0];
    wire [4:0] gate_chg = pin_rise[4:0] | pin_fall[4:0];
    wire [4:0] dir_lvl = pin_lvl[9:5];
    wire [4:0] dir_chg = pin_rise[9:5] | pin_fall[9:5];
    wire cap_rise = pin_rise[10];
    wire cap_fall = pin_fall[10];

    // State
    reg [15:0] ctrl_reg [0:4];
    reg [15:0] capture_reload_reg_reg;
    reg [7:0] flags_reg;
    reg [15:0] pre_reg;
    reg core_tgl_reg;
    reg core_tgl_prev_reg;
    reg sec_tgl_reg;
    reg sec_tgl_prev_reg;
    reg [7:0] wr_addr_reg;
    reg [31:0] wr_data_reg;
    reg [3:0] wr_strb_reg;

    wire [79:0] tval;
    wire [4:0] wrap;

    // Prescaler tick: low n bits of the free counter all ones
    function pre_tick;
        input [15:0] cnt;
        input [3:0] n;
        integer k;
        begin
            pre_tick = 1'b1;
            for (k = 0; k < 16; k = k + 1) begin
                if (k < n && !cnt[k]) begin
                    pre_tick = 1'b0;
                end
            end
        end
    endfunction

    function [15:0] merge16;
        input [15:0] old;
        input [31:0] data;
        input [3:0] strb;
        begin
            merge16 = old;
            if (strb[0]) begin
                merge16[7:0] = data[7:0];
            end
            if (strb[1]) begin
                merge16[15:8] = data[15:8];
            end
        end
    endfunction

    // Toggle latch transitions, seen one cycle after the wrap
    wire core_tgl_rise = core_tgl_reg & ~core_tgl_prev_reg;
    wire core_tgl_fall = ~core_tgl_reg & core_tgl_prev_reg;
    wire sec_tgl_chg = sec_tgl_reg ^ sec_tgl_prev_reg;

    // Write commit once address and data are both held
    wire wr_commit = ~AWREADY & ~WREADY & ~BVALID;
    wire [3:0] wr_idx = wr_addr_reg[5:2];
    wire wr_hit_hi = wr_addr_reg[7:6] == `DTU_ADDR_HI;

    // Per-timer step, direction and hardware loads
    reg [15:0] cfg;
    reg [3:0] ps_n;
    reg tick;
    reg gedge;
    reg src;
    reg enc_up;
    reg [4:0] step;
    reg [4:0] up;
    reg [4:0] hw_load;
    reg [15:0] hw_val [0:4];
    reg [2:0] cap_set;
    reg [4:0] sw_load;
    reg [4:0] load;
    reg [79:0] load_val;

    always @* begin
        cfg = 16'h0;
        ps_n = 4'h0;
        tick = 1'b0;
        gedge = 1'b0;
        src = 1'b0;
        enc_up = 1'b0;
        step = 5'h0;
        up = 5'h0;
        hw_load = 5'h0;
        cap_set = 3'h0;
        sw_load = 5'h0;
        load = 5'h0;
        load_val = 80'h0;
        for (i = 0; i < 5; i = i + 1) begin
            hw_val[i] = 16'h0;
        end
        for (i = 0; i < 5; i = i + 1) begin
            cfg = ctrl_reg[i];
            if (i < 3) begin
                ps_n = `DTU_RES1_LOG2 + {1'b0, cfg[`DTU_F_PS_HI:`DTU_F_PS_LO]};
            end else begin
                ps_n = `DTU_RES2_LOG2 + {1'b0, cfg[`DTU_F_PS_HI:`DTU_F_PS_LO]};
            end
            tick = pre_tick(pre_reg, ps_n);
            gedge = (cfg[`DTU_F_EDGE_RISE] & pin_rise[i])
                | (cfg[`DTU_F_EDGE_FALL] & pin_fall[i]);
            up[i] = ~(cfg[`DTU_F_DOWN] ^ (cfg[`DTU_F_EXTDIR] & dir_lvl[i]));
            enc_up = gate_chg[i] ? (gate_lvl[i] ^ dir_lvl[i]) : ~(gate_lvl[i] ^ dir_lvl[i]);
            case (cfg[`DTU_F_MODE_HI:`DTU_F_MODE_LO])
                `DTU_MODE_TIMER: begin
                    src = tick;
                end
                `DTU_MODE_GATED: begin
                    src = tick & (gate_lvl[i] == cfg[`DTU_F_GATE_LVL]);
                end
                `DTU_MODE_COUNTER: begin
                    // Aux timers may count toggle latch transitions instead of pin edges
                    if (cfg[`DTU_F_TGL_CLK] && (i == `DTU_T_AUXA || i == `DTU_T_AUXB)) begin
                        src = core_tgl_rise | core_tgl_fall;
                    end else if (cfg[`DTU_F_TGL_CLK] && i == `DTU_T_SAUX) begin
                        src = sec_tgl_chg;
                    end else begin
                        src = gedge;
                    end
                end
                `DTU_MODE_ENCODER: begin
                    // Simultaneous edges on both phases are invalid and dropped
                    src = (i < 3) & (gate_chg[i] ^ dir_chg[i]);
                    up[i] = enc_up ^ cfg[`DTU_F_DOWN];
                end
                default: begin
                    src = 1'b0;
                end
            endcase
            step[i] = cfg[`DTU_F_RUN] & src
                & (cfg[`DTU_F_ROLE_HI:`DTU_F_ROLE_LO] == `DTU_ROLE_NONE);
            if (i == `DTU_T_AUXA || i == `DTU_T_AUXB) begin
                if (cfg[`DTU_F_ROLE_HI:`DTU_F_ROLE_LO] == `DTU_ROLE_CAPTURE && gedge) begin
                    hw_load[i] = 1'b1;
                    hw_val[i] = tval[31:16];
                    cap_set[i >> 1] = 1'b1;
                end
                if (cfg[`DTU_F_ROLE_HI:`DTU_F_ROLE_LO] == `DTU_ROLE_RELOAD
                    && !hw_load[`DTU_T_CORE]
                    && (gedge || (cfg[`DTU_F_B14] && core_tgl_rise)
                    || (cfg[`DTU_F_B15] && core_tgl_fall))) begin
                    hw_load[`DTU_T_CORE] = 1'b1;
                    hw_val[`DTU_T_CORE] = tval[i*16 +: 16];
                end
            end
        end
        cfg = ctrl_reg[`DTU_T_SAUX];
        if ((cfg[`DTU_F_EDGE_RISE] & cap_rise) | (cfg[`DTU_F_EDGE_FALL] & cap_fall)
            | (cfg[`DTU_F_GATE_LVL] & gate_chg[`DTU_T_CORE])
            | (cfg[`DTU_F_B15] & dir_chg[`DTU_T_CORE])) begin
            cap_set[2] = 1'b1;
            hw_load[`DTU_T_SAUX] = cfg[`DTU_F_B14];
        end
        if (wrap[`DTU_T_SCORE] && ctrl_reg[`DTU_T_SCORE][`DTU_F_B15]) begin
            hw_load[`DTU_T_SCORE] = 1'b1;
            hw_val[`DTU_T_SCORE] = capture_reload_reg_reg;
        end
        for (i = 0; i < 5; i = i + 1) begin
            sw_load[i] = wr_commit & wr_hit_hi & (wr_idx == `DTU_IDX_VAL0 + i);
            load[i] = sw_load[i] | hw_load[i];
            load_val[i*16 +: 16] = sw_load[i]
                ? merge16(tval[i*16 +: 16], wr_data_reg, wr_strb_reg) : hw_val[i];
        end
    end

    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : g_tmr
            dtu_timer #(.W(16)) u_tmr (
                .clk(CLOCK),
                .rst_n(RST_N),
                .step(step[g]),
                .up(up[g]),
                .load(load[g]),
                .load_val(load_val[g*16 +: 16]),
                .value(tval[g*16 +: 16]),
                .wrap(wrap[g])
            );
        end
    endgenerate

    // Register read view
    reg [31:0] rd_data;
    reg rd_ok;
    wire [3:0] rd_idx = ARADDR[5:2];

    always @* begin
        rd_data = 32'h0;
        rd_ok = ARADDR[7:6] == `DTU_ADDR_HI;
        if (rd_idx <= `DTU_IDX_CTRL4) begin
            rd_data = {16'h0, ctrl_reg[rd_idx[2:0]]};
        end else if (rd_idx >= `DTU_IDX_VAL0 && rd_idx <= `DTU_IDX_VAL4) begin
            rd_data = {16'h0, tval[(rd_idx - `DTU_IDX_VAL0)*16 +: 16]};
        end else if (rd_idx == `DTU_IDX_CAPTURE_RELOAD_REG) begin
            rd_data = {16'h0, capture_reload_reg_reg};
        end else if (rd_idx == `DTU_IDX_FLAGS) begin
            rd_data = {24'h0, flags_reg};
        end else begin
            rd_ok = 1'b0;
        end
    end

    wire wr_ok = wr_hit_hi && (wr_idx <= `DTU_IDX_CTRL4
        || (wr_idx >= `DTU_IDX_VAL0 && wr_idx <= `DTU_IDX_FLAGS));
    wire [7:0] flag_set = {cap_set, wrap};
    wire [7:0] flag_clr = (wr_commit && wr_hit_hi && wr_idx == `DTU_IDX_FLAGS && wr_strb_reg[0])
        ? wr_data_reg[7:0] : 8'h0;

    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            for (i = 0; i < 5; i = i + 1) begin
                ctrl_reg[i] <= `DTU_CTRL_RST;
            end
            capture_reload_reg_reg <= 16'h0;
            flags_reg <= 8'h0;
            pre_reg <= 16'h0;
            core_tgl_reg <= 1'b0;
            core_tgl_prev_reg <= 1'b0;
            sec_tgl_reg <= 1'b0;
            sec_tgl_prev_reg <= 1'b0;
            CORE_TOGGLE_OUT <= 1'b0;
            SECOND_TOGGLE_OUT <= 1'b0;
            SECOND_WRAP_PULSE <= 1'b0;
            AWREADY <= 1'b1;
            WREADY <= 1'b1;
            BVALID <= 1'b0;
            BRESP <= `DTU_RESP_OKAY;
            ARREADY <= 1'b1;
            RVALID <= 1'b0;
            RDATA <= 32'h0;
            RRESP <= `DTU_RESP_OKAY;
            wr_addr_reg <= 8'h0;
            wr_data_reg <= 32'h0;
            wr_strb_reg <= 4'h0;
        end else begin
            pre_reg <= pre_reg + 16'h1;
            core_tgl_reg <= core_tgl_reg ^ wrap[`DTU_T_CORE];
            core_tgl_prev_reg <= core_tgl_reg;
            sec_tgl_reg <= sec_tgl_reg ^ wrap[`DTU_T_SCORE];
            sec_tgl_prev_reg <= sec_tgl_reg;
            CORE_TOGGLE_OUT <= core_tgl_reg & ctrl_reg[`DTU_T_CORE][`DTU_F_B14];
            SECOND_TOGGLE_OUT <= sec_tgl_reg & ctrl_reg[`DTU_T_SCORE][`DTU_F_B14];
            SECOND_WRAP_PULSE <= wrap[`DTU_T_SCORE];
            // A hardware set in the clearing cycle wins
            flags_reg <= (flags_reg & ~flag_clr) | flag_set;
            if (cap_set[2]) begin
                capture_reload_reg_reg <= tval[63:48];
            end
            if (AWREADY && AWVALID) begin
                AWREADY <= 1'b0;
                wr_addr_reg <= AWADDR;
            end
            if (WREADY && WVALID) begin
                WREADY <= 1'b0;
                wr_data_reg <= WDATA;
                wr_strb_reg <= WSTRB;
            end
            if (wr_commit) begin
                BVALID <= 1'b1;
                BRESP <= wr_ok ? `DTU_RESP_OKAY : `DTU_RESP_SLVERR;
                if (wr_hit_hi && wr_idx <= `DTU_IDX_CTRL4) begin
                    ctrl_reg[wr_idx[2:0]] <= merge16(ctrl_reg[wr_idx[2:0]],
                        wr_data_reg, wr_strb_reg);
                end
                if (wr_hit_hi && wr_idx == `DTU_IDX_CAPTURE_RELOAD_REG && !cap_set[2]) begin
                    capture_reload_reg_reg <= merge16(capture_reload_reg_reg, wr_data_reg, wr_strb_reg);
                end
            end
            if (BVALID && BREADY) begin
                BVALID <= 1'b0;
                AWREADY <= 1'b1;
                WREADY <= 1'b1;
            end
            if (ARREADY && ARVALID) begin
                ARREADY <= 1'b0;
                RVALID <= 1'b1;
                RDATA <= rd_data;
                RRESP <= rd_ok ? `DTU_RESP_OKAY : `DTU_RESP_SLVERR;
            end
            if (RVALID && RREADY) begin
                RVALID <= 1'b0;
                ARREADY <= 1'b1;
            end
        end
    end
endmodule

//--- tb/dtu_chk.sv
// Port-level bus and pulse checks for the dual module timer unit
`timescale 1ns/100ps
module dtu_chk (
    input wire CLOCK,
    input wire RST_N,
    input wire AWVALID,
    input wire AWREADY,
    input wire WVALID,
    input wire WREADY,
    input wire BVALID,
    input wire BREADY,
    input wire [1:0] BRESP,
    input wire ARVALID,
    input wire ARREADY,
    input wire RVALID,
    input wire RREADY,
    input wire [31:0] RDATA,
    input wire [1:0] RRESP,
    input wire SECOND_WRAP_PULSE
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);
    property p_aw;
        AWVALID && AWREADY |=> !AWREADY;
    endproperty
    a_aw: assert property (p_aw) else $error("write address ready not dropped");
    property p_w;
        WVALID && WREADY |=> !WREADY;
    endproperty
    a_w: assert property (p_w) else $error("write data ready not dropped");
    property p_bw;
        AWVALID && AWREADY && WVALID && WREADY |-> ##[1:3] BVALID;
    endproperty
    a_bw: assert property (p_bw) else $error("write response late");
    property p_b;
        BVALID && !BREADY |=> BVALID && $stable(BRESP);
    endproperty
    a_b: assert property (p_b) else $error("write response not held");
    property p_r;
        ARVALID && ARREADY |=> RVALID && !ARREADY;
    endproperty
    a_r: assert property (p_r) else $error("read answer not next cycle");
    property p_rh;
        RVALID && !RREADY |=> RVALID && $stable(RDATA);
    endproperty
    a_rh: assert property (p_rh) else $error("read data not held");
    property p_hi;
        RVALID |-> RDATA[31:16] == 16'h0000 && (RRESP == 2'h0 || RRESP == 2'h2);
    endproperty
    a_hi: assert property (p_hi) else $error("read word malformed");
    // A reload value of all ones can wrap every count, so two clocks is the floor unless both gate pin edges count
    property p_wp;
        SECOND_WRAP_PULSE |=> !SECOND_WRAP_PULSE;
    endproperty
    a_wp: assert property (p_wp) else $error("wrap pulse too long");
endmodule
bind dtu_top dtu_chk chk (.CLOCK(CLOCK), .RST_N(RST_N), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA),
    .RRESP(RRESP), .SECOND_WRAP_PULSE(SECOND_WRAP_PULSE));

//--- tb/dtu_pins.sv
// Direction, gate and capture pins driven into the timer unit
`timescale 1ns/100ps
module dtu_pins (
    input wire CLOCK,
    output logic [4:0] GATE_IN,
    output logic [4:0] DIR_IN,
    output logic CAPTURE_IN
);
    initial begin
        GATE_IN = 5'h00;
        DIR_IN = 5'h00;
        CAPTURE_IN = 1'h0;
    end
    // Levels hold 8 clocks: past the synchroniser and the 4-clock count period
    task hold;
        repeat (8) @(posedge CLOCK);
    endtask
    task gate(input int i, input logic v);
        @(posedge CLOCK);
        GATE_IN[i] <= v;
        hold();
    endtask
    task dir(input int i, input logic v);
        @(posedge CLOCK);
        DIR_IN[i] <= v;
        hold();
    endtask
    task pulse(input int i);
        gate(i, 1'h1);
        gate(i, 1'h0);
    endtask
    task cap(input logic v);
        @(posedge CLOCK);
        CAPTURE_IN <= v;
        hold();
    endtask
    // Forward runs a-rise, b-rise, a-fall, b-fall on the core pins
    task quad(input logic fwd);
        @(posedge CLOCK);
        if ((GATE_IN[1] == DIR_IN[1]) == fwd) GATE_IN[1] <= ~GATE_IN[1];
        else DIR_IN[1] <= ~DIR_IN[1];
        hold();
    endtask
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the dual module timer unit
`timescale 1ns/100ps
`include "dtu_regs.vh"
module tb_top;
    localparam [2:0] TA = `DTU_T_AUXA, TC = `DTU_T_CORE, TB = `DTU_T_AUXB;
    localparam [2:0] TS = `DTU_T_SAUX, SC = `DTU_T_SCORE;
    localparam [3:0] FL = `DTU_IDX_FLAGS, CR = `DTU_IDX_CAPTURE_RELOAD_REG;
    logic CLOCK = 1'h0, RST_N = 1'h0;
    logic AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0;
    logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
    logic [31:0] WDATA = 32'h00000000;
    logic [3:0] WSTRB = 4'hf;
    wire AWREADY, WREADY, BVALID, ARREADY, RVALID, CAPTURE_IN;
    wire CORE_TOGGLE_OUT, SECOND_TOGGLE_OUT, SECOND_WRAP_PULSE;
    wire [1:0] BRESP, RRESP;
    wire [31:0] RDATA;
    wire [4:0] GATE_IN, DIR_IN;
    int num_errors = 0, n_tests = 0, wraps = 0;
    dtu_top uut (.CLOCK(CLOCK), .RST_N(RST_N), .GATE_IN(GATE_IN), .DIR_IN(DIR_IN),
        .CAPTURE_IN(CAPTURE_IN), .CORE_TOGGLE_OUT(CORE_TOGGLE_OUT),
        .SECOND_TOGGLE_OUT(SECOND_TOGGLE_OUT), .SECOND_WRAP_PULSE(SECOND_WRAP_PULSE),
        .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR), .WVALID(WVALID),
        .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB), .BVALID(BVALID), .BREADY(BREADY),
        .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
        .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP));
    dtu_pins pins (.CLOCK(CLOCK), .GATE_IN(GATE_IN), .DIR_IN(DIR_IN), .CAPTURE_IN(CAPTURE_IN));
    initial begin
        forever #5 CLOCK = ~CLOCK;
    end
    always @(posedge CLOCK) begin
        if (SECOND_WRAP_PULSE === 1'h1) wraps <= wraps + 1;
    end
    function automatic [3:0] ci(input [2:0] k);
        ci = `DTU_IDX_CTRL0 + {1'h0, k};
    endfunction
    function automatic [3:0] vi(input [2:0] k);
        vi = `DTU_IDX_VAL0 + {1'h0, k};
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chkr(input string n, input logic [15:0] lo, input logic [15:0] hi,
        input logic [15:0] g);
        n_tests++;
        if ((g >= lo && g <= hi) !== 1'h1) begin
            num_errors++;
            $display("unexpected %s expected %h..%h seen %h", n, lo, hi, g);
        end
    endtask
    task automatic wr(input [3:0] i, input [15:0] d, input [1:0] er = `DTU_RESP_OKAY);
        int t = 0;
        @(posedge CLOCK);
        AWADDR <= {`DTU_ADDR_HI, i, 2'h0};
        WDATA <= {16'h0000, d};
        AWVALID <= 1'h1;
        WVALID <= 1'h1;
        BREADY <= 1'h1;
        do begin
            @(posedge CLOCK);
            if (AWREADY) AWVALID <= 1'h0;
            if (WREADY) WVALID <= 1'h0;
            t++;
        end while (!(BVALID && BREADY) && t < 200);
        chk("bvalid", 32'h00000001, BVALID);
        BREADY <= 1'h0;
        chk("bresp", er, BRESP);
    endtask
    task automatic rd(input [3:0] i, output [31:0] d, output [1:0] r);
        int t = 0;
        @(posedge CLOCK);
        ARADDR <= {`DTU_ADDR_HI, i, 2'h0};
        ARVALID <= 1'h1;
        RREADY <= 1'h1;
        do begin
            @(posedge CLOCK);
            if (ARREADY) ARVALID <= 1'h0;
            t++;
        end while (!RVALID && t < 200);
        chk("rvalid", 32'h00000001, RVALID);
        d = RDATA;
        r = RRESP;
        RREADY <= 1'h0;
    endtask
    task automatic rv(input [3:0] i, input [15:0] lo, input [15:0] hi);
        logic [31:0] d;
        logic [1:0] r;
        rd(i, d, r);
        chk("rresp", `DTU_RESP_OKAY, r);
        chkr($sformatf("register %0d", i), lo, hi, d[15:0]);
    endtask
    task automatic t_reset;
        logic [31:0] d;
        logic [1:0] r;
        rv(ci(TC), 16'h0000, 16'h0000);
        rv(vi(SC), 16'h0000, 16'h0000);
        rv(FL, 16'h0000, 16'h0000);
        rd(4'h5, d, r);
        chk("unmapped rresp", `DTU_RESP_SLVERR, r);
        chk("unmapped rdata", 32'h00000000, d);
        wr(4'h5, 16'hffff, `DTU_RESP_SLVERR);
        wr(ci(TA), 16'h0003);
        rv(ci(TA), 16'h0003, 16'h0003);
        wr(ci(TA), 16'h0000);
    endtask
    // Both reads take equally long, so the window is 400 clocks plus one read
    task automatic t_rate(input [2:0] k, input [15:0] c, input [15:0] n);
        logic [31:0] a, b;
        logic [1:0] r;
        wr(vi(k), 16'h0000);
        wr(ci(k), c);
        rd(vi(k), a, r);
        repeat (400) @(posedge CLOCK);
        rd(vi(k), b, r);
        wr(ci(k), 16'h0000);
        chkr("count rate", n - 16'h0001, n + 16'h0002, b[15:0] - a[15:0]);
    endtask
    task automatic t_wrap;
        wr(FL, 16'h00ff);
        wr(vi(TC), 16'h0002);
        wr(ci(TC), 16'h4180);
        repeat (40) @(posedge CLOCK);
        chk("core toggle", 32'h00000001, CORE_TOGGLE_OUT);
        wr(ci(TC), 16'h4000);
        rv(vi(TC), 16'hfff0, 16'hfffe);
        rv(FL, 16'h0002, 16'h0002);
        wr(FL, 16'h0002);
        rv(FL, 16'h0000, 16'h0000);
    endtask
    task automatic t_modes;
        wr(vi(TA), 16'h0000);
        wr(ci(TA), 16'h0890);
        repeat (5) pins.pulse(0);
        rv(vi(TA), 16'h0005, 16'h0005);
        wr(ci(TA), 16'h0000);
        wr(vi(TB), 16'h0000);
        wr(ci(TB), 16'h0488);
        repeat (200) @(posedge CLOCK);
        pins.gate(2, 1'h1);
        repeat (392) @(posedge CLOCK);
        pins.gate(2, 1'h0);
        rv(vi(TB), 16'h0063, 16'h0065);
        wr(ci(TB), 16'h0000);
        wr(vi(TC), 16'h0010);
        wr(ci(TC), 16'h0098);
        repeat (8) pins.quad(1'h1);
        rv(vi(TC), 16'h0018, 16'h0018);
        repeat (3) pins.quad(1'h0);
        rv(vi(TC), 16'h0015, 16'h0015);
        wr(ci(TC), 16'h0000);
    endtask
    task automatic t_cap;
        wr(FL, 16'h00ff);
        wr(vi(TC), 16'h1234);
        wr(vi(TA), 16'h0007);
        wr(ci(TA), 16'h08a0);
        repeat (100) @(posedge CLOCK);
        rv(vi(TA), 16'h0007, 16'h0007);
        pins.pulse(0);
        rv(vi(TA), 16'h1234, 16'h1234);
        rv(FL, 16'h0020, 16'h0020);
        wr(ci(TA), 16'h0000);
        wr(FL, 16'h00ff);
        wr(vi(TS), 16'h0123);
        wr(ci(TS), 16'h4800);
        pins.cap(1'h1);
        rv(CR, 16'h0123, 16'h0123);
        rv(vi(TS), 16'h0000, 16'h0000);
        rv(FL, 16'h0080, 16'h0080);
        pins.cap(1'h0);
        wr(ci(TS), 16'h0000);
    endtask
    task automatic t_more;
        wr(vi(TB), 16'h1234);
        WSTRB <= 4'h2;
        wr(vi(TB), 16'habcd);
        WSTRB <= 4'hf;
        rv(vi(TB), 16'hab34, 16'hab34);
        pins.dir(2, 1'h1);
        wr(vi(TB), 16'h0100);
        wr(ci(TB), 16'h0280);
        repeat (40) @(posedge CLOCK);
        wr(ci(TB), 16'h0000);
        rv(vi(TB), 16'h00f0, 16'h00fe);
        pins.dir(2, 1'h0);
        wr(vi(TS), 16'h0010);
        pins.dir(3, 1'h1);
        wr(ci(TS), 16'h0a90);
        repeat (3) pins.pulse(3);
        rv(vi(TS), 16'h000d, 16'h000d);
        wr(ci(TS), 16'h0400);
        pins.gate(1, ~pins.GATE_IN[1]);
        rv(CR, 16'h000d, 16'h000d);
        wr(ci(TS), 16'h0000);
        pins.dir(3, 1'h0);
        wr(vi(TA), 16'h5555);
        wr(ci(TA), 16'h0840);
        pins.pulse(0);
        rv(vi(TC), 16'h5555, 16'h5555);
        wr(ci(TA), 16'h0000);
    endtask
    task automatic t_reload;
        int w0;
        wr(FL, 16'h00ff);
        wr(CR, 16'h8000);
        wr(vi(SC), 16'hfff8);
        w0 = wraps;
        wr(ci(SC), 16'hc080);
        repeat (60) @(posedge CLOCK);
        wr(ci(SC), 16'hc000);
        chk("wrap pulses", 32'h00000001, wraps - w0);
        chk("second toggle", 32'h00000001, SECOND_TOGGLE_OUT);
        rv(vi(SC), 16'h8000, 16'h8030);
        rv(FL, 16'h0010, 16'h0010);
    endtask
    task automatic results;
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge CLOCK);
        RST_N <= 1'h1;
        t_reset();
        t_rate(TC, 16'h0080, 16'h0064);
        t_rate(TC, 16'h0081, 16'h0032);
        t_rate(SC, 16'h0080, 16'h00c8);
        t_wrap();
        t_modes();
        t_cap();
        t_more();
        t_reload();
        results();
    end
    initial begin
        repeat (40000) @(posedge CLOCK);
        num_errors++;
        results();
    end
endmodule
